// File: hdl/ptc_cfg.svh
// Constants for the panel output timing control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PTC_ADDR_W          12
`define PTC_OFS_TIMING_ONE  12'h400
`define PTC_OFS_TIMING_TWO  12'h404
`define PTC_RST_TIMING_ONE  32'h00000000
`define PTC_RST_TIMING_TWO  32'h00000000
`define PTC_WMASK_ONE       32'h60000000
`define PTC_WMASK_TWO       32'hEFFF0000
`define PTC_RESP_OKAY       2'h0
`define PTC_RESP_SLVERR     2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define PTC_B_IN_VSYNC_POL  30
`define PTC_B_IN_HSYNC_POL  29
`define PTC_B_MCLK_RATIO    31
`define PTC_B_BYPASS        30
`define PTC_B_STROBE_POL    29
`define PTC_B_RESERVED      28
`define PTC_B_SHIFT_FREE    27
`define PTC_B_LINE_SEL      26
`define PTC_B_STROBE_SEL    25
`define PTC_B_FRAME_SEL     24
`define PTC_B_VSYNC_POL     23
`define PTC_B_HSYNC_POL     22
`define PTC_F_TYPE_HI       21
`define PTC_F_TYPE_LO       20
`define PTC_B_MONO          19
`define PTC_F_FMT_HI        18
`define PTC_F_FMT_LO        16

// ****************************************************************
// Codes and counts
// ****************************************************************
`define PTC_TYPE_STN        2'h0
`define PTC_TYPE_TFT        2'h1
`define PTC_FMT_MONO8       3'h0
`define PTC_MCLK_LAST       2'h2
`define PTC_SHF_LAST        2'h1
`define PTC_PACK_LAST       2'h3
`define PTC_SYNC_W          21
`define PTC_PIX_W           18

`endif

// File: hdl/ptc_pkg.sv
// Types shared by the panel output timing control block.
// Assumes ptc_cfg.svh is on the include path.
`include "ptc_cfg.svh"

package ptc_pkg;

  // ****************************************************************
  // Panel type codes
  // ****************************************************************
  typedef logic [1:0] ptc_type_t;

  // ****************************************************************
  // Complete state of the main block
  // ****************************************************************
  typedef struct packed {
    logic                     aw_have;
    logic [`PTC_ADDR_W-1:0]   aw_addr;
    logic                     w_have;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
    logic [31:0]              timing_one;
    logic [31:0]              timing_two;
    logic [1:0]               mclk_cnt;
    logic                     mclk_en;
    logic [1:0]               shf_cnt;
    logic                     shf_clk;
    logic [1:0]               pack_cnt;
    logic [7:0]               pack;
    logic                     line_pin;
    logic                     frame_pin;
    logic                     strobe;
    logic [23:0]              data;
  } ptc_state_s;

endpackage

// File: hdl/ptc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes every bit is an independent level from outside the clock domain.
module ptc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ptc_sync_s;

  ptc_sync_s s;
  ptc_sync_s next_s;

  always_comb
  begin
    next_s        = s;
    next_s.meta   = async_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;

endmodule

// File: hdl/ptc_panel_timing.sv
// Panel output timing control: second panel timing register and output stage.
// Assumes AXI4-Lite master on sys_clk_i, which is also the pixel clock.
// Functional notes
// - Bit 31 picks memory clock full or two-thirds
// - Bypass forwards input timing and pixels directly
// - Normal mode applies polarity and pin controls
// - Strobe active low at 0, high at 1
// - Shift clock idle in retrace unless bit 27 with TFT type; free-running in bypass
// - Line pin: line pulse or horizontal sync
// - Frame pin: first line marker or vertical sync
// - Vertical sync output polarity, TFT frame pin only
// - Input vertical sync polarity from first register
// - Horizontal sync output polarity, TFT line pin only
// - Input horizontal sync polarity from first register
// - Panel type: 00 STN, 01 TFT, rest reserved
// - Data mapping and shift clock follow panel type
// - Bit 19 selects colour or monochrome formatting
// - Second register read/write, resets to zero
// - Mono 8-bit dual-scan shift clock quarter rate
//
// The AXI4-Lite slave port was left to the implementer.
`include "ptc_cfg.svh"
module ptc_panel_timing (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [`PTC_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [`PTC_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  input  wire logic                   line_sync_input_i,
  input  wire logic                   frame_sync_input_i,
  input  wire logic                   display_enable_input_i,
  input  wire logic [`PTC_PIX_W-1:0]  pixel_input_i,
  output logic                        mem_clock_enable_o,
  output logic                        panel_shift_clock_o,
  output logic                        display_enable_strobe_o,
  output logic                        line_pin_o,
  output logic                        frame_pin_o,
  output logic [23:0]                 panel_data_pins_o
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [`PTC_SYNC_W-1:0] syn;
  logic                   in_de;
  logic                   in_vs;
  logic                   in_hs;
  logic [`PTC_PIX_W-1:0]  in_pix;

  ptc_sync #(
    .WIDTH (`PTC_SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({display_enable_input_i, frame_sync_input_i, line_sync_input_i, pixel_input_i}),
    .sync_o    (syn)
  );

  assign in_de  = syn[`PTC_SYNC_W-1];
  assign in_vs  = syn[`PTC_SYNC_W-2];
  assign in_hs  = syn[`PTC_SYNC_W-3];
  assign in_pix = syn[`PTC_PIX_W-1:0];

  ptc_pkg::ptc_state_s s;
  ptc_pkg::ptc_state_s next_s;

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  logic                bypass;
  logic                tft;
  logic                stn;
  logic                quarter;
  logic                run_shift;
  logic                hs_norm;
  logic                vs_norm;
  ptc_pkg::ptc_type_t  ptype;

  assign ptype   = s.timing_two[`PTC_F_TYPE_HI:`PTC_F_TYPE_LO];
  assign bypass  = s.timing_two[`PTC_B_BYPASS];
  assign tft     = (ptype == `PTC_TYPE_TFT);
  assign stn     = (ptype == `PTC_TYPE_STN);
  assign quarter = stn && s.timing_two[`PTC_B_MONO]
                   && (s.timing_two[`PTC_F_FMT_HI:`PTC_F_FMT_LO] == `PTC_FMT_MONO8);
  assign run_shift = in_de || (tft && s.timing_two[`PTC_B_SHIFT_FREE]);
  assign hs_norm = in_hs ^ s.timing_one[`PTC_B_IN_HSYNC_POL];
  assign vs_norm = in_vs ^ s.timing_one[`PTC_B_IN_VSYNC_POL];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    // Write channel capture, in either order
    if (s_axi_awvalid_i && s.awready)
    begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready)
    begin
      next_s.w_have = 1'b1;
      next_s.w_data = s_axi_wdata_i;
      next_s.w_strb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i)
    begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.aw_have && next_s.w_have && !next_s.bvalid)
    begin
      next_s.bvalid  = 1'b1;
      next_s.bresp   = `PTC_RESP_OKAY;
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        if (next_s.w_strb[i])
        begin
          if (next_s.aw_addr == `PTC_OFS_TIMING_ONE)
          begin
            next_s.timing_one[i*8 +: 8] = next_s.w_data[i*8 +: 8];
          end
          if (next_s.aw_addr == `PTC_OFS_TIMING_TWO)
          begin
            next_s.timing_two[i*8 +: 8] = next_s.w_data[i*8 +: 8];
          end
        end
      end
      next_s.timing_one = next_s.timing_one & `PTC_WMASK_ONE;
      next_s.timing_two = next_s.timing_two & `PTC_WMASK_TWO;
      if (next_s.aw_addr != `PTC_OFS_TIMING_ONE && next_s.aw_addr != `PTC_OFS_TIMING_TWO)
      begin
        next_s.bresp = `PTC_RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_have;
    next_s.wready  = !next_s.w_have;

    // Read channel
    if (s.rvalid && s_axi_rready_i)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `PTC_RESP_OKAY;
      next_s.rdata  = 32'h00000000;
      if (s_axi_araddr_i == `PTC_OFS_TIMING_ONE)
      begin
        next_s.rdata = s.timing_one;
      end
      else if (s_axi_araddr_i == `PTC_OFS_TIMING_TWO)
      begin
        next_s.rdata = s.timing_two;
      end
      else
      begin
        next_s.rresp = `PTC_RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;

    // Memory clock enable: every cycle, or two of every three
    if (s.timing_two[`PTC_B_MCLK_RATIO])
    begin
      next_s.mclk_cnt = (s.mclk_cnt == `PTC_MCLK_LAST) ? 2'h0 : s.mclk_cnt + 2'h1;
      next_s.mclk_en  = (next_s.mclk_cnt != `PTC_MCLK_LAST);
    end
    else
    begin
      next_s.mclk_cnt = 2'h0;
      next_s.mclk_en  = 1'b1;
    end

    // Panel output stage
    if (bypass)
    begin
      next_s.line_pin  = in_hs;
      next_s.frame_pin = in_vs;
      next_s.strobe    = in_de;
      next_s.data      = {6'h00, in_pix};
      next_s.shf_clk   = !s.shf_clk;
      next_s.shf_cnt   = 2'h0;
      next_s.pack_cnt  = 2'h0;
    end
    else
    begin
      next_s.line_pin  = s.timing_two[`PTC_B_LINE_SEL]
                         ? (hs_norm ^ s.timing_two[`PTC_B_HSYNC_POL]) : hs_norm;
      next_s.frame_pin = s.timing_two[`PTC_B_FRAME_SEL]
                         ? (vs_norm ^ s.timing_two[`PTC_B_VSYNC_POL]) : vs_norm;
      next_s.strobe    = s.timing_two[`PTC_B_STROBE_POL] ? in_de : !in_de;

      if (!run_shift)
      begin
        next_s.shf_clk = 1'b0;
        next_s.shf_cnt = 2'h0;
      end
      else if (quarter)
      begin
        next_s.shf_cnt = (s.shf_cnt == `PTC_SHF_LAST) ? 2'h0 : s.shf_cnt + 2'h1;
        if (s.shf_cnt == `PTC_SHF_LAST)
        begin
          next_s.shf_clk = !s.shf_clk;
        end
      end
      else
      begin
        next_s.shf_clk = !s.shf_clk;
        next_s.shf_cnt = 2'h0;
      end

      if (tft)
      begin
        next_s.data = {in_pix[17:12], 2'h0, in_pix[11:6], 2'h0, in_pix[5:0], 2'h0};
      end
      else if (stn && !s.timing_two[`PTC_B_MONO])
      begin
        next_s.data = {6'h00, in_pix};
      end
      else if (quarter)
      begin
        // Four pixels of two grey bits form one 8-bit panel word
        if (in_de)
        begin
          next_s.pack     = {s.pack[5:0], in_pix[11:10]};
          next_s.pack_cnt = s.pack_cnt + 2'h1;
          if (s.pack_cnt == `PTC_PACK_LAST)
          begin
            next_s.data = {16'h0000, s.pack[5:0], in_pix[11:10]};
          end
        end
        else
        begin
          next_s.pack_cnt = 2'h0;
        end
      end
      else if (stn)
      begin
        next_s.data = {in_pix[11:6], 2'h0, in_pix[11:6], 2'h0, in_pix[11:6], 2'h0};
      end
      else
      begin
        next_s.data = 24'h000000;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s            <= '0;
      s.timing_one <= `PTC_RST_TIMING_ONE;
      s.timing_two <= `PTC_RST_TIMING_TWO;
      s.mclk_en    <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready_o         = s.awready;
  assign s_axi_wready_o          = s.wready;
  assign s_axi_bresp_o           = s.bresp;
  assign s_axi_bvalid_o          = s.bvalid;
  assign s_axi_arready_o         = s.arready;
  assign s_axi_rdata_o           = s.rdata;
  assign s_axi_rresp_o           = s.rresp;
  assign s_axi_rvalid_o          = s.rvalid;
  assign mem_clock_enable_o      = s.mclk_en;
  assign panel_shift_clock_o     = s.shf_clk;
  assign display_enable_strobe_o = s.strobe;
  assign line_pin_o              = s.line_pin;
  assign frame_pin_o             = s.frame_pin;
  assign panel_data_pins_o       = s.data;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_mclk_full;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !s.timing_two[`PTC_B_MCLK_RATIO] |=> mem_clock_enable_o;
  endproperty
  a_mclk_full: assert property (p_mclk_full) else $error("memory clock not full rate");

  property p_mclk_no_three;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    s.timing_two[`PTC_B_MCLK_RATIO] [*4] |-> !(mem_clock_enable_o && $past(mem_clock_enable_o)
      && $past(mem_clock_enable_o, 2));
  endproperty
  a_mclk_no_three: assert property (p_mclk_no_three) else $error("ratio above two-thirds");

  property p_mclk_no_gap;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    s.timing_two[`PTC_B_MCLK_RATIO] [*3] |-> (mem_clock_enable_o || $past(mem_clock_enable_o));
  endproperty
  a_mclk_no_gap: assert property (p_mclk_no_gap) else $error("ratio below two-thirds");

  property p_bypass;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    bypass |=> (line_pin_o == $past(in_hs)) && (frame_pin_o == $past(in_vs))
      && (display_enable_strobe_o == $past(in_de));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not forward inputs");

  property p_strobe_pol;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !bypass |=> display_enable_strobe_o
      == ($past(s.timing_two[`PTC_B_STROBE_POL]) ? $past(in_de) : !$past(in_de));
  endproperty
  a_strobe_pol: assert property (p_strobe_pol) else $error("strobe polarity wrong");

  property p_line_pin;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !bypass |=> line_pin_o == ($past(in_hs) ^ $past(s.timing_one[`PTC_B_IN_HSYNC_POL])
      ^ ($past(s.timing_two[`PTC_B_LINE_SEL]) && $past(s.timing_two[`PTC_B_HSYNC_POL])));
  endproperty
  a_line_pin: assert property (p_line_pin) else $error("line pin level wrong");

  property p_frame_pin;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !bypass |=> frame_pin_o == ($past(in_vs) ^ $past(s.timing_one[`PTC_B_IN_VSYNC_POL])
      ^ ($past(s.timing_two[`PTC_B_FRAME_SEL]) && $past(s.timing_two[`PTC_B_VSYNC_POL])));
  endproperty
  a_frame_pin: assert property (p_frame_pin) else $error("frame pin level wrong");

  property p_shift_idle;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !bypass && !run_shift |=> !panel_shift_clock_o;
  endproperty
  a_shift_idle: assert property (p_shift_idle) else $error("shift clock ran in retrace");

  property p_quarter;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!bypass && quarter && run_shift && $changed(panel_shift_clock_o)) [*1]
      ##1 (!bypass && quarter && run_shift) |-> $stable(panel_shift_clock_o);
  endproperty
  a_quarter: assert property (p_quarter) else $error("shift clock above quarter rate");

  property p_rsvd_zero;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    1'b1 |-> !s.timing_two[`PTC_B_RESERVED];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit was stored");

endmodule

// File: hdl/ptc_panel_timing_fix.sv
// Holds no logic: the whole block lives in ptc_panel_timing.sv.

// File: sim/ptc_panel_model.sv
// Behavioural panel input: counts shift clock toggles, latches data on rising shift edges.
// Assumes it samples the block's panel outputs on the pixel clock.
module ptc_panel_model (
  input  wire logic        sys_clk_i,
  input  wire logic        clear_i,
  input  wire logic        shift_i,
  input  wire logic [23:0] data_i,
  output logic [7:0]       toggles_o,
  output logic [23:0]      latched_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;

  always_ff @(posedge sys_clk_i)
  begin
    last <= shift_i;
    if (clear_i)
      toggles_o <= 8'h00;
    else if (shift_i != last)
      toggles_o <= toggles_o + 8'h01;
    if (shift_i && !last)
      latched_o <= data_i;
  end
endmodule

// File: sim/test_ptc_panel_timing.sv
// Self-checking bench for the panel output timing control block.
// Assumes the design files under hdl/ and the panel model are compiled first.
module test_ptc_panel_timing;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, awv, wv, bre, arv, rre, hs, vs, de, clr;
  logic [11:0] awa, ara;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [17:0] pix;
  wire         awr, wr_rdy, bv, arr, rv, mce, shf, stb, lp, fp;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  wire  [23:0] pd, lat;
  wire  [7:0]  tog;
  int          err_count, n_compared;

  ptc_panel_timing uut (
    .sys_clk_i(clk), .rstn_i(rstn),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .line_sync_input_i(hs), .frame_sync_input_i(vs), .display_enable_input_i(de),
    .pixel_input_i(pix), .mem_clock_enable_o(mce), .panel_shift_clock_o(shf),
    .display_enable_strobe_o(stb), .line_pin_o(lp), .frame_pin_o(fp),
    .panel_data_pins_o(pd)
  );

  ptc_panel_model panel (
    .sys_clk_i(clk), .clear_i(clr), .shift_i(shf), .data_i(pd),
    .toggles_o(tog), .latched_o(lat)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic hang(input string nm);
    err_count++;
    $display("unexpected %s expected answer seen none", nm);
    wrap_up();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ap, wp, bd;
    ap = 1;
    wp = 1;
    bd = 0;
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (int i = 0; i < 40 && !bd; i++)
    begin
      @(posedge clk);
      if (!ap && !wp && bv === 1'b1)
      begin
        bd = 1;
        r = br;
      end
      if (ap && awr === 1'b1)
      begin
        ap = 0;
        awv <= 1'b0;
      end
      if (wp && wr_rdy === 1'b1)
      begin
        wp = 0;
        wv <= 1'b0;
      end
    end
    if (!bd)
      hang("write response");
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ad, dn;
    ad = 0;
    dn = 0;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (int i = 0; i < 40 && !dn; i++)
    begin
      @(posedge clk);
      if (ad && rv === 1'b1)
      begin
        dn = 1;
        d = rd;
        r = rr;
      end
      if (!ad && arr === 1'b1)
      begin
        ad = 1;
        arv <= 1'b0;
      end
    end
    if (!dn)
      hang("read data");
  endtask

  task automatic cfg(input logic [31:0] one, input logic [31:0] two);
    logic [1:0] r;
    wr(12'h400, one, r);
    chk("resp 400", 32'h0, {30'h0, r});
    wr(12'h404, two | 32'h02000000, r);
    chk("resp 404", 32'h0, {30'h0, r});
    repeat (4) @(posedge clk);
  endtask

  task automatic cnt_mce(output int n);
    n = 0;
    repeat (30)
    begin
      @(posedge clk);
      if (mce === 1'b1)
        n++;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    logic [31:0] sh_cfg [5] = '{32'h00080000, 32'h0, 32'h08000000, 32'h08100000, 32'h00100000};
    logic        sh_de [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int          sh_exp [5] = '{8, 16, 0, 16, 0};
    logic [31:0] sh_lat [5] = '{32'h55, 32'h2D5A3, 32'h2D5A3, 32'hB4588C, 32'hB4588C};
    {awv, wv, bre, arv, rre, hs, vs, de, clr} = 9'h000;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0;
    ws = 4'h0;
    pix = 18'h0;
    err_count = 0;
    n_compared = 0;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdr(12'h404, d, r);
    chk("reset 404", 32'h0, d);
    chk("mem clock enable", 32'h1, {31'h0, mce});
    wr(12'h404, 32'hFFFFFFFF, r);
    rdr(12'h404, d, r);
    chk("readback 404", 32'hEFFF0000, d);
    wr(12'h408, 32'h1, r);
    chk("unmapped bresp", 32'h2, {30'h0, r});
    rdr(12'h408, d, r);
    chk("unmapped rdata", 32'h0, d);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    $display("test registers done");
    cfg(32'h0, 32'h80000000);
    cnt_mce(n);
    chk("mem clock two thirds", 32'd20, n);
    cfg(32'h0, 32'h0);
    cnt_mce(n);
    chk("mem clock full", 32'd30, n);
    $display("test memory clock done");
    for (int j = 0; j < 4; j++)
    begin
      de <= j[1];
      cfg(32'h0, {2'b00, j[0], 29'h0});
      chk("strobe", {31'h0, j[0] ~^ j[1]}, {31'h0, stb});
    end
    $display("test strobe done");
    for (int j = 0; j < 16; j++)
    begin
      hs <= j[3];
      vs <= ~j[3];
      cfg({1'b0, j[0], j[0], 29'h0}, {5'h0, j[1], 1'b0, j[1], j[2], j[2], 22'h0});
      chk("line pin", {31'h0, j[3] ^ j[0] ^ (j[1] & j[2])}, {31'h0, lp});
      chk("frame pin", {31'h0, ~j[3] ^ j[0] ^ (j[1] & j[2])}, {31'h0, fp});
    end
    $display("test sync pins done");
    de <= 1'b1;
    pix <= 18'h2D5A3;
    cfg(32'h0, 32'h00100000);
    chk("tft data", {6'h2D, 2'b0, 6'h16, 2'b0, 6'h23, 2'b0}, {8'h0, pd});
    cfg(32'h0, 32'h00200000);
    chk("reserved type data", 32'h0, {8'h0, pd});
    cfg(32'h0, 32'h0);
    chk("colour stn data", {14'h0, 18'h2D5A3}, {8'h0, pd});
    $display("test data done");
    for (int k = 0; k < 5; k++)
    begin
      de <= sh_de[k];
      cfg(32'h0, sh_cfg[k]);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (17) @(posedge clk);
      chk("shift toggles", sh_exp[k], {24'h0, tog});
      chk("panel latched data", sh_lat[k], {8'h0, lat});
    end
    $display("test shift clock done");
    hs <= 1'b1;
    de <= 1'b1;
    cfg(32'h0, 32'h44400000);
    chk("bypass line", 32'h1, {31'h0, lp});
    chk("bypass strobe", 32'h1, {31'h0, stb});
    $display("test bypass done");
    wrap_up();
  end
endmodule
